// ==== design/mrspt_top.sv ====
// What this block does
// - mode 0: timer reset on enable, held
// - mode 0: timer starts at start-record word
// - mode 1: timer resets and runs at enable
// - mode 1: finalize restarts timer, new packet
// - packet completion raises enabled ready interrupt
// - select 00: start on valid command word
// - select 01: start on valid any-sync word
// - data-sync start sets sync error flag
// - select 10: command sync plus two bits
// - select 11: any sync plus two bits
// - mode and select are host RW, reset 0
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module mrspt_top
    import mrspt_pkg::*;
#(
    parameter int TIMER_W = 32
)(
    input  wire logic        clock,        // 100 MHz
    input  wire logic        nrst,         // async reset, active low
    input  wire logic [3:0]  addr,         // register word address
    input  wire logic [15:0] wdata,        // write data
    input  wire logic        wr,           // write strobe
    input  wire logic        rd,           // read strobe
    output logic      [15:0] rdata,        // read data, cycle after rd
    input  wire logic        sync_det,     // decoder: sync + 2 bits
    input  wire logic        sync_is_cmd,  // decoder: sync type
    input  wire logic        word_done,    // decoder: word complete
    input  wire logic        word_ok,      // decoder: word valid
    input  wire logic        word_is_cmd,  // decoder: word sync type
    input  wire logic        msg_end,      // message recording ended
    input  wire logic        pkt_final,    // packet finalized
    output logic             recording,    // a message is recording
    output logic             msg_start,    // pulse: message begins
    output logic [15:0]      bsw,          // block status word flags
    output logic [TIMER_W-1:0] pkt_timer,  // packet timer
    output logic             packet_ready_irq // level interrupt
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the timer read port shows the low 16 bits, so narrower is refused
    if (TIMER_W < 16 || TIMER_W > 64)
    begin : g_timer_w_check
        $error("mrspt_top: TIMER_W must be 16..64");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0]  cfg_q;
    logic         en_q;
    logic         en_prev_q;
    logic [1:0]   irq_stat_q;
    logic [1:0]   irq_mask_q;
    logic [15:0]  rdata_q;
    logic [15:0]  bsw_q;
    logic         run_q;
    logic         rec_q;
    logic [TIMER_W-1:0] tmr_q;
    mrspt_state_t state_q;

    logic         packet_timer_mode;
    logic [1:0]   start_record_select;
    logic         q_start;
    logic         q_sync_err;
    logic         q_frag;
    logic         en_rise;
    logic         fin_sw;
    logic         fin;
    logic         begin_msg;
    logic [1:0]   irq_set;
    logic         q_frag_pending;

    // ----------------------------------------------------------------
    // qualifier and decode
    // ----------------------------------------------------------------
    assign packet_timer_mode   = cfg_q[MRSPT_PTM_BIT];
    assign start_record_select = cfg_q[MRSPT_SRS_LSB +: 2];
    assign en_rise = en_q && !en_prev_q;
    assign fin_sw  = wr && (addr == MRSPT_CTRL_ADDR) && wdata[MRSPT_FIN_BIT];
    // a software finalize counts only while enabled, like the decoder one
    assign fin     = en_q && (pkt_final || fin_sw);

    mrspt_start_qual u_qual (
        .start_record_select (start_record_select),
        .sync_det            (sync_det),
        .sync_is_cmd         (sync_is_cmd),
        .word_done           (word_done),
        .word_ok             (word_ok),
        .word_is_cmd         (word_is_cmd),
        .start               (q_start),
        .sync_err            (q_sync_err),
        .frag_start          (q_frag)
    );

    // a message opens on a qualified word once the packet has left idle,
    // and never while another message is still recording
    assign begin_msg = en_q && (state_q != MRSPT_IDLE) && !rec_q && q_start;

    // ----------------------------------------------------------------
    // host configuration
    // ----------------------------------------------------------------
    // the unused bits of the word are plain storage for software
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            cfg_q <= MRSPT_CFG_RST;
        else if (wr && addr == MRSPT_CFG_ADDR)
            cfg_q <= wdata;
    end

    // ----------------------------------------------------------------
    // enable
    // ----------------------------------------------------------------
    // en_prev_q turns the enable write into a one-cycle rise
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q      <= 1'b0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= en_q;
            if (wr && addr == MRSPT_CTRL_ADDR)
                en_q <= wdata[MRSPT_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // packet state
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            state_q <= MRSPT_IDLE;
        else if (!en_q)
            state_q <= MRSPT_IDLE;
        else
        begin
            case (state_q)
                MRSPT_IDLE:
                begin
                    // idle lasts one cycle so the timer clear lands first
                    if (packet_timer_mode)
                        state_q <= MRSPT_REC;
                    else
                        state_q <= MRSPT_WAIT;
                end
                MRSPT_WAIT:
                begin
                    if (begin_msg)
                        state_q <= MRSPT_REC;
                end
                MRSPT_REC:
                begin
                    // mode 0 goes back to waiting for the next start word,
                    // unless a start word lands on the finalize cycle
                    if (fin && !packet_timer_mode && !begin_msg)
                        state_q <= MRSPT_WAIT;
                end
                default:
                    // illegal codes fall back to idle
                    state_q <= MRSPT_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // packet timer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tmr_q <= '0;
            run_q <= 1'b0;
        end
        else if (!en_q || en_rise)
        begin
            tmr_q <= '0;
            run_q <= en_rise && packet_timer_mode;
        end
        else if (fin)
        begin
            // restart only in mode 1; mode 0 waits for the next start,
            // which may fall on this very cycle
            tmr_q <= '0;
            run_q <= packet_timer_mode || begin_msg;
        end
        else if (begin_msg && !run_q)
        begin
            // mode 0 holds at zero until the first start word of a packet
            tmr_q <= '0;
            run_q <= 1'b1;
        end
        else if (run_q)
            tmr_q <= tmr_q + TIMER_W'(1);
    end

    // ----------------------------------------------------------------
    // message recording and block status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rec_q <= 1'b0;
            bsw_q <= '0;
        end
        else if (!en_q)
            rec_q <= 1'b0;
        else if (begin_msg)
        begin
            // flags belong to the message being opened
            rec_q <= 1'b1;
            bsw_q <= '0;
            bsw_q[MRSPT_BSW_SYNC_BIT] <= q_sync_err;
        end
        else if (rec_q && (msg_end || fin))
            rec_q <= 1'b0;
        else if (rec_q && q_frag_pending && word_done && !word_ok)
            bsw_q[MRSPT_BSW_INV_BIT] <= 1'b1;
    end

    // a fragment start arms the invalid-word check for its own word;
    // the next word end, good or bad, or the end of recording disarms it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            q_frag_pending <= 1'b0;
        else if (begin_msg)
            q_frag_pending <= q_frag;
        else if (word_done || !rec_q)
            q_frag_pending <= 1'b0;
    end

    // ----------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins
    // ----------------------------------------------------------------
    assign irq_set[MRSPT_IRQ_PKT_BIT]   = fin;
    // the start bit lets software see traffic without polling the state
    assign irq_set[MRSPT_IRQ_START_BIT] = begin_msg;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_stat_q <= MRSPT_IRQ_RST;
            irq_mask_q <= MRSPT_IRQ_RST;
        end
        else
        begin
            if (wr && addr == MRSPT_MASK_ADDR)
                irq_mask_q <= wdata[1:0];
            // a same-cycle event beats the clear so no event is lost
            if (wr && addr == MRSPT_STATUS_ADDR)
                irq_stat_q <= (irq_stat_q & ~wdata[1:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    assign packet_ready_irq = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    // zero outside the read cycle so several slaves can share a bus
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= '0;
        else if (!rd)
            rdata_q <= '0;
        else if (addr == MRSPT_CFG_ADDR)
            rdata_q <= cfg_q;
        else if (addr == MRSPT_STATUS_ADDR)
            rdata_q <= {14'h0000, irq_stat_q};
        else if (addr == MRSPT_MASK_ADDR)
            rdata_q <= {14'h0000, irq_mask_q};
        else if (addr == MRSPT_CTRL_ADDR)
            rdata_q <= {15'h0000, en_q};
        else if (addr == MRSPT_TIMER_ADDR)
            rdata_q <= tmr_q[15:0];
        else if (addr == MRSPT_BSW_ADDR)
            rdata_q <= bsw_q;
        else if (addr == MRSPT_STATE_ADDR)
            rdata_q <= {11'h000, run_q, rec_q, 3'(state_q)};
        else
            rdata_q <= '0;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata     = rdata_q;
    // per message; the open packet itself shows in the state register
    assign recording = rec_q;
    assign msg_start = begin_msg;
    assign bsw       = bsw_q;
    assign pkt_timer = tmr_q;

endmodule : mrspt_top

// ==== design/mrspt_pkg.sv ====
package mrspt_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0]  MRSPT_CFG_ADDR      = 4'h0;
    localparam logic [3:0]  MRSPT_STATUS_ADDR   = 4'h1;
    localparam logic [3:0]  MRSPT_MASK_ADDR     = 4'h2;
    localparam logic [3:0]  MRSPT_CTRL_ADDR     = 4'h3;
    localparam logic [3:0]  MRSPT_TIMER_ADDR    = 4'h4;
    localparam logic [3:0]  MRSPT_BSW_ADDR      = 4'h5;
    localparam logic [3:0]  MRSPT_STATE_ADDR    = 4'h6;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          MRSPT_PTM_BIT       = 7;
    localparam int          MRSPT_SRS_LSB       = 5;
    localparam int          MRSPT_EN_BIT        = 0;
    localparam int          MRSPT_FIN_BIT       = 1;
    localparam int          MRSPT_IRQ_PKT_BIT   = 0;
    localparam int          MRSPT_IRQ_START_BIT = 1;
    localparam int          MRSPT_BSW_SYNC_BIT  = 0;
    localparam int          MRSPT_BSW_INV_BIT   = 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] MRSPT_CFG_RST       = 16'h0000;
    localparam logic [1:0]  MRSPT_IRQ_RST       = 2'h0;

    // ----------------------------------------------------------------
    // start-record selections
    // ----------------------------------------------------------------
    localparam logic [1:0]  MRSPT_SRS_CMD_WORD  = 2'h0;
    localparam logic [1:0]  MRSPT_SRS_ANY_WORD  = 2'h1;
    localparam logic [1:0]  MRSPT_SRS_CMD_FRAG  = 2'h2;
    localparam logic [1:0]  MRSPT_SRS_ANY_FRAG  = 2'h3;

    typedef enum logic [2:0] {
        MRSPT_IDLE = 3'b001,
        MRSPT_WAIT = 3'b010,
        MRSPT_REC  = 3'b100
    } mrspt_state_t;

endpackage : mrspt_pkg

// ==== design/mrspt_start_qual.sv ====
`timescale 1ns/10ps
module mrspt_start_qual
    import mrspt_pkg::*;
(
    input  wire logic [1:0] start_record_select, // qualifier choice
    input  wire logic       sync_det,       // sync + two data bits seen
    input  wire logic       sync_is_cmd,    // 1 command sync, 0 data sync
    input  wire logic       word_done,      // complete word decoded
    input  wire logic       word_ok,        // manchester good, odd parity
    input  wire logic       word_is_cmd,    // completed word had cmd sync
    output logic            start,          // begin a message now
    output logic            sync_err,       // began on data sync
    output logic            frag_start      // began on a fragment
);

    always_comb
    begin
        start      = 1'b0;
        sync_err   = 1'b0;
        frag_start = 1'b0;
        case (start_record_select)
            MRSPT_SRS_CMD_WORD:
            begin
                start = word_done && word_ok && word_is_cmd;
            end
            MRSPT_SRS_ANY_WORD:
            begin
                start    = word_done && word_ok;
                sync_err = word_done && word_ok && !word_is_cmd;
            end
            MRSPT_SRS_CMD_FRAG:
            begin
                start      = sync_det && sync_is_cmd;
                frag_start = start;
            end
            default:
            begin
                start      = sync_det;
                frag_start = start;
                sync_err   = sync_det && !sync_is_cmd;
            end
        endcase
    end

endmodule : mrspt_start_qual

// ==== dv/mrspt_assertions.sv ====
`timescale 1ns/10ps
module mrspt_checker
    import mrspt_pkg::*;
#(
    parameter int TIMER_W = 32
)(
    input wire logic               clock, // clock
    input wire logic               nrst, // reset
    input wire logic               wr, // write
    input wire logic               rd, // read
    input wire logic [15:0]        rdata, // read data
    input wire logic               sync_det, // sync seen
    input wire logic               sync_is_cmd, // sync kind
    input wire logic               word_done, // word end
    input wire logic               word_ok, // word good
    input wire logic               word_is_cmd, // word kind
    input wire logic               msg_end, // msg over
    input wire logic               pkt_final, // finalize
    input wire logic               recording, // recording
    input wire logic               msg_start, // start
    input wire logic [15:0]        bsw, // flags
    input wire logic [TIMER_W-1:0] pkt_timer, // timer
    input wire logic               packet_ready_irq // irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0)
        else $error("read data not zero outside read cycle");
    a_start_cause: assert property (msg_start |-> (sync_det || word_done)
        && !recording ##1 recording) else $error("bad message start");
    a_word_good: assert property (msg_start && word_done |-> word_ok)
        else $error("start on invalid word");
    a_data_sync: assert property (msg_start && (word_done ? !word_is_cmd
        : !sync_is_cmd) |=> bsw[0]) else $error("sync error flag missing");
    a_rec_hold: assert property (recording && !msg_end && !pkt_final
        && !wr |=> recording) else $error("recording dropped");
    a_timer_run: assert property (recording && $past(recording)
        && !$past(pkt_final) && !$past(wr)
        |-> pkt_timer == $past(pkt_timer) + 1) else $error("timer stalled");
    a_final_zero: assert property (pkt_final |=> pkt_timer == '0)
        else $error("timer not reset at finalize");
    a_irq_cause: assert property ($rose(packet_ready_irq)
        |-> $past(pkt_final) || $past(msg_start) || $past(wr))
        else $error("interrupt without cause");
endmodule : mrspt_checker

bind mrspt_top mrspt_checker #(.TIMER_W(TIMER_W)) u_chk (
    .clock(clock), .nrst(nrst), .wr(wr), .rd(rd), .rdata(rdata),
    .sync_det(sync_det), .sync_is_cmd(sync_is_cmd), .word_done(word_done),
    .word_ok(word_ok), .word_is_cmd(word_is_cmd), .msg_end(msg_end),
    .pkt_final(pkt_final), .recording(recording), .msg_start(msg_start),
    .bsw(bsw), .pkt_timer(pkt_timer), .packet_ready_irq(packet_ready_irq));

// ==== dv/mrspt_bus_model.sv ====
`timescale 1ns/10ps
module mrspt_bus_model (
    input  wire logic clock, // clock
    output logic      sync_det, // sync plus two bits
    output logic      sync_is_cmd, // sync kind
    output logic      word_done, // word complete
    output logic      word_ok, // word valid
    output logic      word_is_cmd // word sync kind
);
    logic busy_q = 1'b0;
    logic frag_q = 1'b0;
    logic cmd_q  = 1'b0;
    logic ok_q   = 1'b0;
    logic tick_q = 1'b0;

    // qualifiers toggle while idle so stale values never look valid
    always @(posedge clock)
        tick_q <= ~tick_q;

    // kind: 0 good cmd word, 1 good data word, 2 bad cmd word,
    // 3 cmd sync fragment, 4 data sync fragment
    task automatic put(input int kind);
        @(posedge clock);
        busy_q <= 1'b1;
        frag_q <= kind > 2;
        cmd_q  <= kind != 1 && kind != 4;
        ok_q   <= kind < 2;
    endtask : put

    task automatic drop;
        @(posedge clock);
        busy_q <= 1'b0;
    endtask : drop

    assign sync_det    = busy_q & frag_q;
    assign word_done   = busy_q & ~frag_q;
    assign sync_is_cmd = busy_q ? cmd_q : tick_q;
    assign word_is_cmd = busy_q ? cmd_q : ~tick_q;
    assign word_ok     = busy_q ? ok_q : tick_q;
endmodule : mrspt_bus_model

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
    import mrspt_pkg::*;
    logic        clock, nrst, wr, rd, msg_end, pkt_final;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, bsw, r;
    logic        sync_det, sync_is_cmd, word_done, word_ok, word_is_cmd;
    logic        recording, msg_start, packet_ready_irq;
    logic [31:0] pkt_timer, t0;
    int          mismatches = 0, comparisons = 0, cycles = 0, e;

    mrspt_top #(.TIMER_W(32)) dut (.clock(clock), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sync_det(sync_det),
        .sync_is_cmd(sync_is_cmd), .word_done(word_done), .word_ok(word_ok),
        .word_is_cmd(word_is_cmd), .msg_end(msg_end), .pkt_final(pkt_final),
        .recording(recording), .msg_start(msg_start), .bsw(bsw),
        .pkt_timer(pkt_timer), .packet_ready_irq(packet_ready_irq));
    mrspt_bus_model bus (.clock(clock), .sync_det(sync_det),
        .sync_is_cmd(sync_is_cmd), .word_done(word_done), .word_ok(word_ok),
        .word_is_cmd(word_is_cmd));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------
    // tasks
    // ------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a, input logic [15:0] x);
        @(posedge clock);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, x);
    endtask : rreg

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic pulse(input bit fin);
        @(posedge clock);
        pkt_final <= fin;
        msg_end   <= !fin;
        @(posedge clock);
        pkt_final <= 1'b0;
        msg_end   <= 1'b0;
        #1;
    endtask : pulse

    // reference: bit0 start expected, bit1 sync error expected
    function automatic int expect_start(input int sel, input int kind);
        case (sel)
            0: return (kind == 0) ? 1 : 0;
            1: return (kind < 2) ? 1 + 2 * kind : 0;
            2: return (kind == 3) ? 1 : 0;
            default: return (kind > 2) ? 1 + 2 * (kind - 3) : 0;
        endcase
    endfunction : expect_start

    // ------
    // tests
    // ------
    initial
    begin
        void'($urandom(32'h919b));
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0;
        msg_end = 1'b0;
        pkt_final = 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rreg(MRSPT_CFG_ADDR, 16'h0);
        r = 16'($urandom);
        wreg(MRSPT_CFG_ADDR, r);
        rreg(MRSPT_CFG_ADDR, r);
        rreg(4'hf, 16'h0);
        $display("test 1 done");
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 5; k++)
            begin
                e = expect_start(s, k);
                wreg(MRSPT_CFG_ADDR, 16'(s << MRSPT_SRS_LSB));
                wreg(MRSPT_CTRL_ADDR, 16'h0001);
                tick(1 + $urandom_range(3));
                chk(pkt_timer, 0);
                bus.put(k);
                #1 chk(msg_start, e[0]);
                bus.drop();
                #1 chk(recording, e[0]);
                if (e[0])
                begin
                    chk(bsw[1:0], {1'b0, e[1]});
                    t0 = pkt_timer;
                    tick(4);
                    chk(pkt_timer, t0 + 4);
                    if (k > 2)
                    begin
                        bus.put(2);
                        bus.drop();
                        #1 chk(bsw[1], 1'b1);
                    end
                    pulse(1'b0);
                    chk(recording, 1'b0);
                end
                wreg(MRSPT_CTRL_ADDR, 16'h0);
            end
        $display("test 2 done");
        for (int m = 0; m < 2; m++)
        begin
            wreg(MRSPT_STATUS_ADDR, 16'h0003);
            wreg(MRSPT_MASK_ADDR, 16'(m));
            wreg(MRSPT_CFG_ADDR, 16'h0);
            wreg(MRSPT_CTRL_ADDR, 16'h0001);
            tick(2);
            bus.put(0);
            bus.drop();
            tick(3);
            pulse(1'b0);
            bus.put(0);
            #1 chk(msg_start, 1'b1);
            bus.drop();
            pulse(1'b1);
            chk(pkt_timer, 0);
            chk(packet_ready_irq, m);
            rreg(MRSPT_STATUS_ADDR, 16'h0003);
            wreg(MRSPT_STATUS_ADDR, 16'h0003);
            #1 chk(packet_ready_irq, 1'b0);
            wreg(MRSPT_CTRL_ADDR, 16'h0);
        end
        $display("test 3 done");
        wreg(MRSPT_CFG_ADDR, 16'h0080);
        wreg(MRSPT_CTRL_ADDR, 16'h0001);
        tick(2);
        chk(recording, 1'b0);
        t0 = pkt_timer;
        tick(5);
        chk(pkt_timer, t0 + 5);
        bus.put(0);
        #1 chk(msg_start, 1'b1);
        bus.drop();
        pulse(1'b1);
        chk(pkt_timer, 0);
        chk(recording, 1'b0);
        chk(packet_ready_irq, 1'b1);
        tick(3);
        chk(pkt_timer, 3);
        rreg(MRSPT_STATE_ADDR, {11'h000, 2'b10, 3'(MRSPT_REC)});
        $display("test 4 done");
        report_and_stop;
    end
endmodule : tb
